//--- adcswr_readout.sv
// adcswr_readout: conversion pacing, sleep control and serial word readout
// assumes result and flags come from the filter on clk_i and are valid at each word end;
// osc_tick_i is a one-cycle enable per internal oscillator period
//
// Operation
// (RULE1) external variant: master clock is serial clock; one word per 612 periods
// (RULE2) internal variant: one word per 612 oscillator periods regardless of serial clock
// (RULE3) internal variant: serial clock only shifts data and controls sleep
// (RULE4) host keeps external serial clock at most 130 kHz or 200 kHz
// (RULE5) conversions run continuously after reset without any host command
// (RULE6) fresh word and chip select low: data out driven low as ready
// (RULE7) chip select high: data out kept high-impedance
// (RULE8) external variant: ready low appears on a serial clock rising edge
// (RULE9) shifting starts after the fall following ready; first bit 1.5 cycles
// (RULE10) a word read takes 24 serial clock cycles after first fall
// (RULE11) next bit presented after falling edge; host samples on rising edge
// (RULE12) after last bit, data out stays high until next word
// (RULE13) chip select high at word end: output waits until chip select low
// (RULE14) word under read never overwritten; conversions ending meanwhile dropped
// (RULE15) host may skip words by holding chip select high a cycle
// (RULE16) chip select rising mid-read abandons word; next result replaces it
// (RULE17) internal variant: serial clock asynchronous, up to 2 MHz
// (RULE18) word: 0, overrange, oscillation, 0, then two's complement result msb first
// (RULE19) overrange flag follows each word's own overrange state
// (RULE20) clock high for entry time sleeps; low for 10 us wakes
// (RULE21) four conversions after reset or wake before a word is valid
// (RULE22) result width parameter; 16-bit result padded with four leading zeros
`timescale 1ns/100ps
module adcswr_readout #(
    parameter logic        EXT_CLOCK          = 1'b1,
    parameter int unsigned RESULT_BITS        = adcswr_pkg::FULL_RESULT_BITS,
    parameter int unsigned SLEEP_ENTRY_CYCLES = adcswr_pkg::SLEEP_ENTRY_CYCLES
) (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // internal oscillator enable
    input  wire logic                   osc_tick_i,
    // filter result
    input  wire logic [RESULT_BITS-1:0] result_i,
    input  wire logic                   overrange_flag_i,
    input  wire logic                   modulator_oscillation_flag_i,
    // serial pins
    input  wire logic                   serial_clk_i,
    input  wire logic                   chip_select_n_i,
    output logic                        serial_data_out_o,
    output logic                        serial_data_out_oe_n_o,
    // status
    output logic                        sleeping_o,
    output logic                        word_end_o
);
    logic sclk_lvl;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_n_lvl;

    adcswr_pin_sync #(.RESET_LEVEL(1'b0)) u_sclk_sync ( // [RULE17]
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (serial_clk_i),
        .level_o (sclk_lvl),
        .rise_o  (sclk_rise),
        .fall_o  (sclk_fall)
    );

    adcswr_pin_sync #(.RESET_LEVEL(1'b1)) u_cs_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (chip_select_n_i),
        .level_o (cs_n_lvl),
        .rise_o  (),
        .fall_o  ()
    );

    // builds the serial word from flags and result
    function automatic logic [23:0] pack_word(input logic                   of_f,
                                              input logic                   od_f,
                                              input logic [RESULT_BITS-1:0] res);
        logic [23:0] w;
        w = adcswr_pkg::WORD_RESET;
        w[RESULT_BITS-1:0] = res;                         // [RULE22]
        w[adcswr_pkg::OVERRANGE_BIT]   = of_f;            // [RULE18] [RULE19]
        w[adcswr_pkg::OSCILLATION_BIT] = od_f;            // [RULE18]
        return w;
    endfunction

    // ---------------- sleep and pacing state
    logic [31:0] high_cnt_q, high_cnt_d;
    logic [31:0] low_cnt_q,  low_cnt_d;
    logic        sleep_q,    sleep_d;
    logic [9:0]  div_q,      div_d;
    logic [2:0]  settle_q,   settle_d;
    logic        word_end_q, word_end_d;
    logic        master_tick;
    logic        conv_end;
    logic        word_ok;

    always_comb begin
        high_cnt_d = sclk_lvl ? ((high_cnt_q == 32'hffffffff) ? high_cnt_q : high_cnt_q + 32'h1)
                              : adcswr_pkg::PIN_CNT_RESET;
        low_cnt_d  = sclk_lvl ? adcswr_pkg::PIN_CNT_RESET
                              : ((low_cnt_q == 32'hffffffff) ? low_cnt_q : low_cnt_q + 32'h1);
        sleep_d    = sleep_q;
        settle_d   = settle_q;
        div_d      = div_q;
        conv_end   = 1'b0;
        word_ok    = 1'b0;
        // master tick source depends on variant
        master_tick = EXT_CLOCK ? sclk_rise : osc_tick_i;            // [RULE1] [RULE2] [RULE3]
        if (!sleep_q && sclk_lvl && high_cnt_q >= SLEEP_ENTRY_CYCLES - 1) begin
            sleep_d = 1'b1;                                          // [RULE20]
        end else if (sleep_q && !sclk_lvl && low_cnt_q >= adcswr_pkg::WAKE_CYCLES - 1) begin
            sleep_d  = 1'b0;                                         // [RULE20]
            settle_d = adcswr_pkg::SETTLE_RESET;                     // [RULE21]
            div_d    = adcswr_pkg::DIV_RESET;
        end else if (!sleep_q && master_tick) begin                  // [RULE5]
            if (div_q == adcswr_pkg::DIV_LAST) begin
                div_d    = adcswr_pkg::DIV_RESET;
                conv_end = 1'b1;                                     // [RULE1] [RULE2]
                word_ok  = (settle_q == adcswr_pkg::SETTLE_LAST);    // [RULE21]
                if (settle_q != adcswr_pkg::SETTLE_LAST) begin
                    settle_d = settle_q + 3'h1;
                end
            end else begin
                div_d = div_q + 10'h1;
            end
        end
        word_end_d = conv_end;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            high_cnt_q <= adcswr_pkg::PIN_CNT_RESET;
            low_cnt_q  <= adcswr_pkg::PIN_CNT_RESET;
            sleep_q    <= 1'b0;
            div_q      <= adcswr_pkg::DIV_RESET;
            settle_q   <= adcswr_pkg::SETTLE_RESET;
            word_end_q <= 1'b0;
        end else begin
            high_cnt_q <= high_cnt_d;
            low_cnt_q  <= low_cnt_d;
            sleep_q    <= sleep_d;
            div_q      <= div_d;
            settle_q   <= settle_d;
            word_end_q <= word_end_d;
        end
    end

    // ---------------- readout state
    adcswr_pkg::adcswr_state_type state_q, state_d;
    logic [23:0] word_q,  word_d;
    logic        fresh_q, fresh_d;
    logic [4:0]  idx_q,   idx_d;
    logic        sdo_q,   sdo_d;
    logic        oe_n_q,  oe_n_d;
    logic        reading;
    logic        have;

    always_comb begin
        state_d = state_q;
        word_d  = word_q;
        fresh_d = fresh_q;
        idx_d   = idx_q;
        reading = (state_q == adcswr_pkg::ADCSWR_SHIFT);
        // new word replaces unread one, never one under read
        if (conv_end && word_ok && !reading) begin                   // [RULE14]
            word_d  = pack_word(overrange_flag_i, modulator_oscillation_flag_i, result_i);
            fresh_d = 1'b1;
        end
        have = fresh_q | fresh_d;
        case (state_q)
            adcswr_pkg::ADCSWR_IDLE: begin
                // ready waits for chip select low; external variant on a rise
                if (have && !cs_n_lvl && (!EXT_CLOCK || sclk_rise)) begin // [RULE6] [RULE8] [RULE13]
                    state_d = adcswr_pkg::ADCSWR_READY;
                end
            end
            adcswr_pkg::ADCSWR_READY: begin
                if (cs_n_lvl) begin
                    state_d = adcswr_pkg::ADCSWR_IDLE;               // [RULE13]
                end else if (sclk_fall) begin
                    state_d = adcswr_pkg::ADCSWR_SHIFT;              // [RULE9]
                    idx_d   = adcswr_pkg::FIRST_BIT_INDEX;
                    fresh_d = 1'b0;
                end
            end
            adcswr_pkg::ADCSWR_SHIFT: begin
                if (cs_n_lvl) begin
                    state_d = adcswr_pkg::ADCSWR_IDLE;               // [RULE16]
                end else if (sclk_fall) begin
                    if (idx_q == 5'h00) begin
                        state_d = adcswr_pkg::ADCSWR_IDLE;           // [RULE10] [RULE12]
                    end else begin
                        idx_d = idx_q - 5'h01;                       // [RULE11]
                    end
                end
            end
            default: begin
                state_d = adcswr_pkg::ADCSWR_IDLE;
            end
        endcase
        // pin drive from next state
        case (state_d)
            adcswr_pkg::ADCSWR_READY: sdo_d = 1'b0;                  // [RULE6]
            adcswr_pkg::ADCSWR_SHIFT: sdo_d = word_d[idx_d];         // [RULE9] [RULE11] [RULE18]
            default:                  sdo_d = 1'b1;                  // [RULE12]
        endcase
        oe_n_d = cs_n_lvl;                                           // [RULE7]
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= adcswr_pkg::ADCSWR_IDLE;
            word_q  <= adcswr_pkg::WORD_RESET;
            fresh_q <= 1'b0;
            idx_q   <= adcswr_pkg::FIRST_BIT_INDEX;
            sdo_q   <= 1'b1;
            oe_n_q  <= 1'b1;
        end else begin
            state_q <= state_d;
            word_q  <= word_d;
            fresh_q <= fresh_d;
            idx_q   <= idx_d;
            sdo_q   <= sdo_d;
            oe_n_q  <= oe_n_d;
        end
    end

    always_comb begin
        serial_data_out_o      = sdo_q;
        serial_data_out_oe_n_o = oe_n_q;
        sleeping_o             = sleep_q;
        word_end_o             = word_end_q;
    end
endmodule // adcswr_readout

//--- adcswr_pkg.sv
// adcswr_pkg: constants and types for the converter serial word readout
// assumes a 250 MHz system clock and a 24-bit serial output word
package adcswr_pkg;

    // clock rate
    localparam int unsigned CLK_FREQ_KHZ        = 250000;

    // conversion pacing: one word per this many master clock periods
    localparam int unsigned OUTPUT_WORD_RATE_DIV = 612;
    localparam int unsigned DIV_W                = 10;
    localparam logic [9:0]  DIV_LAST             = 10'h263;
    localparam logic [9:0]  DIV_RESET            = 10'h000;

    // filter settling: conversions needed after power-up or wake
    localparam int unsigned SETTLE_WORDS         = 4;
    localparam logic [2:0]  SETTLE_LAST          = 3'h3;
    localparam logic [2:0]  SETTLE_RESET         = 3'h0;

    // word layout
    localparam int unsigned WORD_BITS            = 24;
    localparam logic [4:0]  FIRST_BIT_INDEX      = 5'h17;
    localparam int unsigned OVERRANGE_BIT        = 22;
    localparam int unsigned OSCILLATION_BIT      = 21;
    localparam int unsigned FULL_RESULT_BITS     = 20;
    localparam logic [23:0] WORD_RESET           = 24'h000000;

    // sleep timing, times in microseconds
    localparam int unsigned SLEEP_ENTRY_TIME_US  = 200;
    localparam int unsigned WAKE_TIME_US         = 10;
    localparam int unsigned SLEEP_ENTRY_CYCLES   = SLEEP_ENTRY_TIME_US * CLK_FREQ_KHZ / 1000;
    localparam int unsigned WAKE_CYCLES          = WAKE_TIME_US * CLK_FREQ_KHZ / 1000;
    localparam logic [31:0] PIN_CNT_RESET        = 32'h00000000;

    // readout states, gray along idle -> ready -> shift
    typedef enum logic [1:0] {
        ADCSWR_IDLE  = 2'b00,
        ADCSWR_READY = 2'b01,
        ADCSWR_SHIFT = 2'b11
    } adcswr_state_type;

endpackage

//--- adcswr_pin_sync.sv
// adcswr_pin_sync: two-flop synchroniser for a pin with edge detection
// assumes the pin is asynchronous to clk_i
`timescale 1ns/100ps
module adcswr_pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // pin and synchronised view
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= RESET_LEVEL;
            sync_q <= RESET_LEVEL;
            prev_q <= RESET_LEVEL;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edges seen only after the second flop
    always_comb begin
        level_o = sync_q;
        rise_o  = sync_q & ~prev_q;
        fall_o  = ~sync_q & prev_q;
    end
endmodule // adcswr_pin_sync

//--- adcswr_readout_props.sv
// adcswr_readout_props: port assertions for the serial word readout
// assumes the external clock variant, bound onto every readout
`timescale 1ns/100ps
module adcswr_readout_props (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // serial pins and status
    input wire logic serial_clk_i,
    input wire logic chip_select_n_i,
    input wire logic serial_data_out_o,
    input wire logic serial_data_out_oe_n_o,
    input wire logic sleeping_o,
    input wire logic word_end_o
);
    logic       sclk_q, seen_q, seen_d;
    logic [9:0] cnt_q, cnt_d;
    logic [2:0] wrd_q, wrd_d;
    // clock rises per word, words since reset or sleep
    always_comb begin
        seen_d = (seen_q | word_end_o) & ~sleeping_o;
        cnt_d  = (word_end_o | sleeping_o) ? 10'h000 : cnt_q + {9'h000, serial_clk_i & ~sclk_q};
        wrd_d  = sleeping_o ? 3'h0 : wrd_q + {2'h0, word_end_o & (wrd_q != 3'h4)};
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {sclk_q, seen_q, cnt_q, wrd_q} <= {2'b00, 10'h000, 3'h0};
        end else begin
            {sclk_q, seen_q, cnt_q, wrd_q} <= {serial_clk_i, seen_d, cnt_d, wrd_d};
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_hiz_deselected: assert property (chip_select_n_i [*5] |-> serial_data_out_oe_n_o)
        else $error("driven while deselected");
    a_oe_release: assert property ($rose(chip_select_n_i) |-> ##[1:5] serial_data_out_oe_n_o)
        else $error("slow release");
    a_drive_selected: assert property (!chip_select_n_i [*5] |-> !serial_data_out_oe_n_o)
        else $error("not driving while selected");
    a_ready_selected: assert property ($fell(serial_data_out_oe_n_o) |-> !$past(chip_select_n_i, 2))
        else $error("drive without select");
    a_word_spacing: assert property (word_end_o |=> !word_end_o [*8])
        else $error("word ends too close");
    a_word_rate: assert property (word_end_o && seen_q |-> cnt_q == 10'h264)
        else $error("word period wrong");
    a_converts_on: assert property (!sleeping_o |-> cnt_q <= 10'h265)
        else $error("conversions stalled");
    a_settle_quiet: assert property (wrd_d < 3'h4 && !serial_data_out_oe_n_o |-> serial_data_out_o)
        else $error("ready before settling");
endmodule // adcswr_readout_props
bind adcswr_readout adcswr_readout_props u_props (.clk_i(clk_i), .rst_i(rst_i),
    .serial_clk_i(serial_clk_i), .chip_select_n_i(chip_select_n_i),
    .serial_data_out_o(serial_data_out_o), .serial_data_out_oe_n_o(serial_data_out_oe_n_o),
    .sleeping_o(sleeping_o), .word_end_o(word_end_o));

//--- adcswr_host_model.sv
// adcswr_host_model: host that clocks the serial pin and reads words
// assumes a free-running serial clock, far faster than the pin rating for short runs
`timescale 1ns/100ps
module adcswr_host_model #(
    parameter int HALF = 6 // rate scaled to clk_i; the block sees only the ratio
) (
    // clock
    input  wire logic   clk_i,
    // serial pins
    input  wire logic   cs_n_i,
    input  wire logic   sdo_i,
    output logic        sclk_o,
    // captured words
    output logic [23:0] word_o,
    output logic [4:0]  bits_o,
    output int          words_o
);
    int ph = 0;
    initial begin
        sclk_o  = 1'b0;
        word_o  = 24'h000000;
        bits_o  = 5'h00;
        words_o = 0;
    end
    always @(negedge clk_i) begin
        ph = (ph == HALF - 1) ? 0 : ph + 1;
        if (ph == 0) begin
            sclk_o <= ~sclk_o;
            if (cs_n_i) begin
                bits_o <= 5'h00;
            end else if (!sclk_o && (bits_o != 5'h00 || !sdo_i)) begin
                word_o  <= {word_o[22:0], sdo_i};
                bits_o  <= (bits_o == 5'h17) ? 5'h00 : bits_o + 5'h01;
                words_o <= words_o + int'(bits_o == 5'h17);
            end
        end
    end
endmodule // adcswr_host_model

//--- adcswr_readout_bench.sv
// adcswr_readout_bench: self-checking bench for the serial word readout
// assumes the host model as serial clock source and reader
`timescale 1ns/100ps
module adcswr_readout_bench;
    localparam int HALF = 6;
    logic        clk_i = 1'b0, rst_i = 1'b1, cs_n = 1'b1, ov = 1'b0, od = 1'b0, use_prev = 1'b0;
    logic [19:0] res = 20'h00000;
    logic [23:0] exp_q, prev_q, hword;
    logic [31:0] rnd;
    logic [4:0]  hbits;
    logic        sclk, serial_data_out, oe_n, sdo_wire, wend, slp, sclk_pin;
    logic        park = 1'b0, park_lvl = 1'b0;
    int          hwords, n, wends = 0, err_total = 0, samples_checked = 0, seed = 32'hd70dd5ba;
    always #2 clk_i = ~clk_i;
    // released line shows the inverse of its last level
    assign sdo_wire = oe_n ? ~serial_data_out : serial_data_out;
    // sleep tests park the clock pin at a fixed level
    assign sclk_pin = park ? park_lvl : sclk;
    adcswr_readout #(.EXT_CLOCK(1'b1), .RESULT_BITS(20), .SLEEP_ENTRY_CYCLES(64)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .osc_tick_i(1'b0), .result_i(res),
        .overrange_flag_i(ov), .modulator_oscillation_flag_i(od), .serial_clk_i(sclk_pin),
        .chip_select_n_i(cs_n), .serial_data_out_o(serial_data_out), .serial_data_out_oe_n_o(oe_n),
        .sleeping_o(slp), .word_end_o(wend));
    adcswr_host_model #(.HALF(HALF)) host (.clk_i(clk_i), .cs_n_i(cs_n), .sdo_i(sdo_wire),
        .sclk_o(sclk), .word_o(hword), .bits_o(hbits), .words_o(hwords));
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask
    function automatic logic [23:0] pack(input logic o, input logic d, input logic [19:0] r);
        return {1'b0, o, d, 1'b0, r};
    endfunction
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_word(input int k);
        repeat (k) begin
            @(negedge clk_i);
            while (wend !== 1'b1) @(negedge clk_i);
        end
    endtask
    // select just after a clock rise, well ahead of the next one
    task automatic select;
        @(posedge sclk);
        @(negedge clk_i);
        cs_n = 1'b0;
    endtask
    // fresh filter output after each word end, corner values after the fifth and sixth
    always @(negedge clk_i) if (wend === 1'b1) begin
        wends++;
        if (wends == 4) check("settle", hwords, 0);
        prev_q = exp_q;
        exp_q = pack(ov, od, res);
        rnd = $random(seed);
        {ov, od, res} = (wends == 5) ? {2'b11, 20'h80000} :
                        (wends == 6) ? {2'b00, 20'h7ffff} : rnd[21:0];
    end
    always @(hwords) if (hwords > 0) begin
        @(negedge clk_i);
        check("word", hword, use_prev ? prev_q : exp_q);
        repeat (20) @(negedge clk_i);
        check("idle", {oe_n, serial_data_out}, 2'b01);
    end
    initial begin
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        select();
        wait_word(6);
        check("reads", hwords, 2);
        wait (hbits == 5'h0a);
        @(negedge clk_i);
        cs_n = 1'b1;
        repeat (20) @(negedge clk_i);
        select();
        n = hwords;
        wait_word(1);
        check("abandoned", hwords, n);
        repeat (500) @(negedge clk_i);
        cs_n = 1'b1;
        wait_word(1);
        n = hwords;
        repeat (612 * 2 * HALF - 150) @(negedge clk_i);
        use_prev = 1'b1;
        select();
        wait (hwords == n + 1);
        repeat (30) @(negedge clk_i);
        use_prev = 1'b0;
        wait_word(1);
        check("dropped", hwords, n + 1);
        // clock held high until asleep, then low until awake
        cs_n = 1'b1;
        park_lvl = 1'b1;
        park = 1'b1;
        repeat (100) @(negedge clk_i);
        check("asleep", slp, 1'b1);
        park_lvl = 1'b0;
        repeat (2400) @(negedge clk_i);
        check("still asleep", slp, 1'b1);
        repeat (150) @(negedge clk_i);
        check("awake", slp, 1'b0);
        summarize();
    end
    initial begin
        repeat (12 * 612 * 2 * HALF) @(negedge clk_i);
        err_total++;
        summarize();
    end
endmodule // adcswr_readout_bench
